// ---- core_model.sv ----
// Behavioural processor core that accepts maskable trap requests.
`timescale 1ns/1ps
module core_model (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_in,
  // Request from the controller.
  input wire logic req_in,
  input wire intc_pkg::vector_t vec_in,
  input wire intc_pkg::level_t lvl_in,
  // Software update of the status word, and a stall that makes the core slow.
  input wire logic load_in,
  input wire logic en_in,
  input wire intc_pkg::level_t thr_in,
  input wire logic stall_in,
  // Status word and accepted traps.
  output logic accept_enable_out,
  output intc_pkg::level_t threshold_out,
  output logic taken_out,
  output intc_pkg::vector_t taken_vec_out
);
  import intc_pkg::*;
  // The core trusts the request; acceptance masks traps and raises the threshold.
  always_ff @(posedge clk_in) begin
    taken_out <= 1'b0;
    if (rst_in) begin
      accept_enable_out <= 1'b0;
      threshold_out <= 4'h0;
      taken_vec_out <= 7'h00;
    end else if (req_in && accept_enable_out && !stall_in) begin
      taken_out <= 1'b1;
      taken_vec_out <= vec_in;
      accept_enable_out <= 1'b0;
      threshold_out <= lvl_in;
    end else if (load_in) begin
      accept_enable_out <= en_in;
      threshold_out <= thr_in;
    end
  end
endmodule

// ---- intc_asserts.sv ----
// Checker of the interrupt controller's core and transfer outputs.
`timescale 1ns/1ps
module intc_asserts (
  // Clock and reset.
  input wire logic CORE_CLK_IN,
  input wire logic RESET_IN,
  // Core side.
  input wire logic CPU_ACCEPT_ENABLE_IN,
  input wire intc_pkg::level_t CPU_PRIORITY_THRESHOLD_IN,
  input wire logic NMI_PENDING_IN,
  input wire logic CPU_REQ_OUT,
  input wire intc_pkg::vector_t CPU_VECTOR_OUT,
  input wire intc_pkg::level_t CPU_LEVEL_OUT,
  input wire logic [31:0] VECTOR_ADDR_OUT,
  // Transfer side and write channel.
  input wire logic XFER_REQ_OUT,
  input wire logic [4:0] XFER_CH_OUT,
  input wire logic XFER_DONE_IN,
  input wire logic AWVALID_IN,
  input wire logic WVALID_IN,
  input wire logic BVALID_OUT
);
  import intc_pkg::*;
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (RESET_IN);
  // The request is registered, so it answers the core's inputs of the previous cycle.
  chk_vec_range: assert property (CPU_REQ_OUT |-> CPU_VECTOR_OUT inside {[7'h10:7'h41]})
    else $error("Request vector outside the maskable range.");
  chk_vec_addr: assert property (CPU_REQ_OUT |-> VECTOR_ADDR_OUT[9:0] == {1'b0, CPU_VECTOR_OUT, 2'b00})
    else $error("Vector address does not match the vector.");
  chk_req_gate: assert property (CPU_REQ_OUT |-> $past(CPU_ACCEPT_ENABLE_IN) && !$past(NMI_PENDING_IN))
    else $error("Request raised while the core refused traps.");
  chk_level_gate: assert property (CPU_REQ_OUT |-> CPU_LEVEL_OUT > $past(CPU_PRIORITY_THRESHOLD_IN))
    else $error("Request level not above the core threshold.");
  // A pending flag keeps its request until software writes or the core changes.
  chk_req_sticky: assert property (CPU_REQ_OUT && CPU_ACCEPT_ENABLE_IN && !NMI_PENDING_IN &&
    CPU_PRIORITY_THRESHOLD_IN < CPU_LEVEL_OUT && !AWVALID_IN && !WVALID_IN && !BVALID_OUT |=> CPU_REQ_OUT)
    else $error("Request lost while its flag should stay set.");
  chk_xfer_hold: assert property (XFER_REQ_OUT && !XFER_DONE_IN |=> XFER_REQ_OUT && $stable(XFER_CH_OUT))
    else $error("Transfer request dropped before completion.");
  chk_xfer_drop: assert property (XFER_REQ_OUT && XFER_DONE_IN |=> !XFER_REQ_OUT)
    else $error("Transfer request held after completion.");
  chk_xfer_chan: assert property (XFER_REQ_OUT |-> XFER_CH_OUT inside {[5'h01:5'h1b]})
    else $error("Transfer launched on a channel that does not exist.");
endmodule
bind maskable_interrupt_controller intc_asserts u_chk (.*);

// ---- intc_consts.svh ----
// Register offsets, reset values and response codes of the interrupt controller.
`ifndef INTC_CONSTS_SVH
`define INTC_CONSTS_SVH
`define NUM_SLOTS 50
`define NUM_SYS 11
`define VEC_FIRST 7'h10
`define VALID_SLOTS 50'h3_77ff_ffff_f73f
`define BOOT_BASE_HIGH 32'h0008_0000
`define BOOT_BASE_LOW 32'h00c0_0000
`define OFS_FLAG_LO 8'h00
`define OFS_FLAG_HI 8'h04
`define OFS_EN_LO 8'h08
`define OFS_EN_HI 8'h0c
`define OFS_XSEL_LO 8'h10
`define OFS_XSEL_HI 8'h14
`define OFS_XPOST_LO 8'h18
`define OFS_XPOST_HI 8'h1c
`define OFS_LVL_LO 8'h20
`define OFS_LVL_HI 8'h24
`define OFS_VBASE 8'h28
`define OFS_EDGE 8'h2c
`define OFS_STATE 8'h30
`define OFS_IRQ_STAT 8'h34
`define OFS_IRQ_MASK 8'h38
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
`define SLOTS_HI_W 18
`endif

// ---- intc_pkg.sv ----
// Types shared by the interrupt controller files.
package intc_pkg;
  typedef enum logic {XF_IDLE, XF_BUSY} xfer_state_t;
  typedef logic [6:0] vector_t;
  typedef logic [3:0] level_t;
endpackage

// ---- maskable_interrupt_controller.sv ----
// Maskable interrupt controller with factor flags, levels, arbitration and transfer launch.
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`include "intc_consts.svh"
// Summary of operation
// - Forty-five maskable factors in eleven systems, one system per peripheral group.
// - Factor slot n owns vector 16+n; entry address is base plus four times vector.
// - Vector base resets to boot address chosen by boot-area select; software may move it.
// - Only factors with a transfer channel may launch a list-driven transfer.
// - One programmable priority level per system, shared by all its factors.
// - Equal levels resolve by fixed factor order, factor 0 highest.
// - Inside a system, factor-number order fixes relative priority.
// - Request needs enable, accept-enable, level above threshold, and no higher trap.
// - An occurrence sets a sticky flag until software clears it.
// - Only the highest-priority pending factor is signalled; others stay pending.
// - Input-port flags set on the chosen rising or falling pin edge.
// - Clock-timer flag sets on falling edge of chosen tick, or count-up.
// - Transfer-launching factors run the transfer first, then request unless disabled.
module maskable_interrupt_controller (
  // Clock and reset.
  input wire logic CORE_CLK_IN,
  input wire logic RESET_IN,
  // Pins and peripheral events.
  input wire logic BOOT_AREA_SELECT_IN,
  input wire logic [12:0] PORT_PIN_IN,
  input wire logic [48:8] PERIPH_EVENT_IN,
  input wire logic [3:0] CLK_TICK_IN,
  input wire logic CLK_COUNTUP_IN,
  // Core side.
  input wire logic CPU_ACCEPT_ENABLE_IN,
  input wire intc_pkg::level_t CPU_PRIORITY_THRESHOLD_IN,
  input wire logic NMI_PENDING_IN,
  output logic CPU_REQ_OUT,
  output intc_pkg::vector_t CPU_VECTOR_OUT,
  output intc_pkg::level_t CPU_LEVEL_OUT,
  output logic [31:0] VECTOR_ADDR_OUT,
  // List-driven transfer side.
  output logic XFER_REQ_OUT,
  output logic [4:0] XFER_CH_OUT,
  input wire logic XFER_DONE_IN,
  // Interrupt to the system.
  output logic IRQ_OUT,
  // AXI4-Lite slave.
  input wire logic [7:0] AWADDR_IN,
  input wire logic AWVALID_IN,
  output logic AWREADY_OUT,
  input wire logic [31:0] WDATA_IN,
  input wire logic [3:0] WSTRB_IN,
  input wire logic WVALID_IN,
  output logic WREADY_OUT,
  output logic [1:0] BRESP_OUT,
  output logic BVALID_OUT,
  input wire logic BREADY_IN,
  input wire logic [7:0] ARADDR_IN,
  input wire logic ARVALID_IN,
  output logic ARREADY_OUT,
  output logic [31:0] RDATA_OUT,
  output logic [1:0] RRESP_OUT,
  output logic RVALID_OUT,
  input wire logic RREADY_IN
);
  import intc_pkg::*;

  // Maps a factor slot to its interrupt system.
  function automatic logic [3:0] sys_of(input int i);
    if (i < 4) return 4'h0;
    if (i < 8) return 4'h1;
    if (i < 12) return 4'h2;
    if (i < 20) return 4'h3;
    if (i < 28) return 4'h4;
    if (i < 36) return 4'h5;
    if (i < 40) return 4'h6;
    if (i < 44) return 4'h7;
    if (i < 48) return 4'h8;
    if (i < 49) return 4'h9;
    return 4'ha;
  endfunction

  // Transfer channel of a factor slot; zero means the factor cannot launch one.
  function automatic logic [4:0] xfer_chan(input int i);
    case (i)
      0: return 5'h01;  1: return 5'h02;  2: return 5'h03;  3: return 5'h04;
      8: return 5'h05;  9: return 5'h06;  14: return 5'h07; 15: return 5'h08;
      18: return 5'h09; 19: return 5'h0a; 22: return 5'h0b; 23: return 5'h0c;
      26: return 5'h0d; 27: return 5'h0e; 30: return 5'h0f; 31: return 5'h10;
      34: return 5'h11; 35: return 5'h12; 36: return 5'h13; 37: return 5'h14;
      38: return 5'h15; 39: return 5'h16; 41: return 5'h17; 42: return 5'h18;
      45: return 5'h19; 46: return 5'h1a; 48: return 5'h1b;
      default: return 5'h00;
    endcase
  endfunction

  // Byte-lane merge for a register write.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  logic [49:0] flag, enable, xsel, xpost, pend, ev, launch, chan_ok, w1c_flag;
  logic [43:0] lvl;
  logic [27:10] vbase;
  logic [5:0] port_pol;
  logic [1:0] tick_sel;
  logic [1:0] irq_stat, irq_mask, w1c_irq;
  logic [12:0] pin_s1, pin_s2, pin_prev;
  logic boot_s1, boot_s2, boot_load;
  logic [3:0] tick_prev;
  logic [7:0] aw_addr, ar_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_have, w_have, wr_go, xfer_finish;
  xfer_state_t xf_state;
  logic [5:0] xf_slot;
  logic found;
  logic [5:0] win_slot;
  level_t win_lvl;

  // Pins are asynchronous; two flops before any logic looks at them.
  always_ff @(posedge CORE_CLK_IN) begin
    pin_s1 <= PORT_PIN_IN;
    pin_s2 <= pin_s1;
    boot_s1 <= BOOT_AREA_SELECT_IN;
    boot_s2 <= boot_s1;
  end

  // Edge history for ports and clock-timer ticks.
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      pin_prev <= 13'h0000;
      tick_prev <= 4'h0;
    end else begin
      pin_prev <= pin_s2;
      tick_prev <= CLK_TICK_IN;
    end
  end

  // Occurrence of each factor in this cycle.
  always_comb begin
    logic [12:0] rise, fall;
    rise = pin_s2 & ~pin_prev;
    fall = ~pin_s2 & pin_prev;
    ev = 50'h0;
    // Pin 3 feeds slot 0 and pin 0 feeds slot 3.
    for (int k = 0; k < 4; k++) begin
      ev[k] = port_pol[k] ? rise[3-k] : fall[3-k];
    end
    ev[4] = port_pol[4] ? |rise[7:4] : |fall[7:4];
    ev[5] = port_pol[5] ? |rise[12:8] : |fall[12:8];
    ev[48:8] = PERIPH_EVENT_IN;
    ev[49] = (tick_prev[tick_sel] & ~CLK_TICK_IN[tick_sel]) | CLK_COUNTUP_IN;
    ev = ev & `VALID_SLOTS;
  end

  // Launch only where a channel exists and software selected it.
  always_comb begin
    for (int i = 0; i < `NUM_SLOTS; i++) begin
      chan_ok[i] = (xfer_chan(i) != 5'h00);
    end
    launch = ev & xsel & chan_ok;
  end

  assign xfer_finish = (xf_state == XF_BUSY) && XFER_DONE_IN;

  // Factor flags: a new occurrence outranks a software clear in the same cycle.
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      flag <= 50'h0;
    end else begin
      flag <= (flag & ~w1c_flag) | (ev & ~launch)
        | ((xfer_finish && xpost[xf_slot]) ? (50'h1 << xf_slot) : 50'h0);
    end
  end

  // Transfer sequencer: lowest pending slot first, one channel at a time.
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      xf_state <= XF_IDLE;
      pend <= 50'h0;
      xf_slot <= 6'h00;
      XFER_REQ_OUT <= 1'b0;
      XFER_CH_OUT <= 5'h00;
    end else begin
      pend <= (pend & ~(xfer_finish ? (50'h1 << xf_slot) : 50'h0)) | launch;
      case (xf_state)
        XF_IDLE: begin
          for (int i = `NUM_SLOTS - 1; i >= 0; i--) begin
            if (pend[i]) begin
              xf_slot <= 6'(i);
              XFER_CH_OUT <= xfer_chan(i);
              XFER_REQ_OUT <= 1'b1;
              xf_state <= XF_BUSY;
            end
          end
        end
        XF_BUSY: begin
          if (XFER_DONE_IN) begin
            XFER_REQ_OUT <= 1'b0;
            xf_state <= XF_IDLE;
          end
        end
        default: xf_state <= XF_IDLE;
      endcase
    end
  end

  // Arbiter: scan from the lowest priority up so a lower slot wins a tie.
  always_comb begin
    level_t l;
    found = 1'b0;
    win_slot = 6'h00;
    win_lvl = 4'h0;
    l = 4'h0;
    for (int i = `NUM_SLOTS - 1; i >= 0; i--) begin
      l = lvl[sys_of(i)*4 +: 4];
      if (flag[i] && enable[i] && (!found || l >= win_lvl)) begin
        found = 1'b1;
        win_slot = 6'(i);
        win_lvl = l;
      end
    end
  end

  // Request to the core with the winner's vector and level.
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      CPU_REQ_OUT <= 1'b0;
      CPU_VECTOR_OUT <= `VEC_FIRST;
      CPU_LEVEL_OUT <= 4'h0;
      VECTOR_ADDR_OUT <= 32'h0;
    end else begin
      CPU_REQ_OUT <= found && CPU_ACCEPT_ENABLE_IN && !NMI_PENDING_IN
        && (win_lvl > CPU_PRIORITY_THRESHOLD_IN);
      CPU_VECTOR_OUT <= `VEC_FIRST + 7'(win_slot);
      CPU_LEVEL_OUT <= win_lvl;
      VECTOR_ADDR_OUT <= {4'h0, vbase, 10'h000} + {23'h0, `VEC_FIRST + 7'(win_slot), 2'b00};
    end
  end

  assign wr_go = aw_have && w_have && !BVALID_OUT;

  // Write-one-clear masks, honouring byte strobes.
  always_comb begin
    logic [31:0] m;
    m = merge(32'h0, w_data, w_strb);
    w1c_flag = 50'h0;
    w1c_irq = 2'b00;
    if (wr_go && aw_addr == `OFS_FLAG_LO) w1c_flag[31:0] = m;
    if (wr_go && aw_addr == `OFS_FLAG_HI) w1c_flag[49:32] = m[`SLOTS_HI_W-1:0];
    if (wr_go && aw_addr == `OFS_IRQ_STAT) w1c_irq = m[1:0];
  end

  // Software-written control registers.
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      enable <= 50'h0;
      xsel <= 50'h0;
      xpost <= 50'h0;
      lvl <= 44'h0;
      port_pol <= 6'h00;
      tick_sel <= 2'h0;
      irq_mask <= 2'h0;
    end else if (wr_go) begin
      case (aw_addr)
        `OFS_EN_LO: enable[31:0] <= merge(enable[31:0], w_data, w_strb);
        `OFS_EN_HI: enable[49:32] <= 18'(merge({14'h0, enable[49:32]}, w_data, w_strb));
        `OFS_XSEL_LO: xsel[31:0] <= merge(xsel[31:0], w_data, w_strb);
        `OFS_XSEL_HI: xsel[49:32] <= 18'(merge({14'h0, xsel[49:32]}, w_data, w_strb));
        `OFS_XPOST_LO: xpost[31:0] <= merge(xpost[31:0], w_data, w_strb);
        `OFS_XPOST_HI: xpost[49:32] <= 18'(merge({14'h0, xpost[49:32]}, w_data, w_strb));
        `OFS_LVL_LO: lvl[31:0] <= merge(lvl[31:0], w_data, w_strb);
        `OFS_LVL_HI: lvl[43:32] <= 12'(merge({20'h0, lvl[43:32]}, w_data, w_strb));
        `OFS_EDGE: {tick_sel, port_pol} <= 8'(merge({24'h0, tick_sel, port_pol}, w_data, w_strb));
        `OFS_IRQ_MASK: irq_mask <= 2'(merge({30'h0, irq_mask}, w_data, w_strb));
        default: ;
      endcase
    end
  end

  // Vector base: boot address caught after reset release, later relocatable.
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      boot_load <= 1'b1;
      vbase <= 18'(`BOOT_BASE_LOW >> 10);
    end else if (boot_load) begin
      boot_load <= 1'b0;
      vbase <= 18'((boot_s2 ? `BOOT_BASE_HIGH : `BOOT_BASE_LOW) >> 10);
    end else if (wr_go && aw_addr == `OFS_VBASE) begin
      vbase <= 18'(merge({4'h0, vbase, 10'h0}, w_data, w_strb) >> 10);
    end
  end

  // Sticky system interrupt: transfer done and an enabled factor flag pending; set beats clear.
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      irq_stat <= 2'b00;
      IRQ_OUT <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~w1c_irq) | {found, xfer_finish};
      IRQ_OUT <= |(irq_stat & irq_mask);
    end
  end

  // Write channels: address and data taken in either order, one write at a time.
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      AWREADY_OUT <= 1'b1;
      WREADY_OUT <= 1'b1;
      BVALID_OUT <= 1'b0;
      BRESP_OUT <= `RESP_OKAY;
    end else begin
      if (AWVALID_IN && AWREADY_OUT) begin
        aw_have <= 1'b1;
        aw_addr <= AWADDR_IN;
        AWREADY_OUT <= 1'b0;
      end
      if (WVALID_IN && WREADY_OUT) begin
        w_have <= 1'b1;
        w_data <= WDATA_IN;
        w_strb <= WSTRB_IN;
        WREADY_OUT <= 1'b0;
      end
      if (wr_go) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        BVALID_OUT <= 1'b1;
        BRESP_OUT <= (aw_addr > `OFS_IRQ_MASK || aw_addr[1:0] != 2'b00
          || aw_addr == `OFS_STATE) ? `RESP_DECERR : `RESP_OKAY;
      end
      if (BVALID_OUT && BREADY_IN) begin
        BVALID_OUT <= 1'b0;
        AWREADY_OUT <= 1'b1;
        WREADY_OUT <= 1'b1;
      end
    end
  end

  // Read channel; the answer comes one cycle after the address is taken.
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      ARREADY_OUT <= 1'b1;
      RVALID_OUT <= 1'b0;
      RDATA_OUT <= 32'h0;
      RRESP_OUT <= `RESP_OKAY;
    end else if (ARVALID_IN && ARREADY_OUT) begin
      ARREADY_OUT <= 1'b0;
      RVALID_OUT <= 1'b1;
      RRESP_OUT <= `RESP_OKAY;
      case (ARADDR_IN)
        `OFS_FLAG_LO: RDATA_OUT <= flag[31:0];
        `OFS_FLAG_HI: RDATA_OUT <= {14'h0, flag[49:32]};
        `OFS_EN_LO: RDATA_OUT <= enable[31:0];
        `OFS_EN_HI: RDATA_OUT <= {14'h0, enable[49:32]};
        `OFS_XSEL_LO: RDATA_OUT <= xsel[31:0];
        `OFS_XSEL_HI: RDATA_OUT <= {14'h0, xsel[49:32]};
        `OFS_XPOST_LO: RDATA_OUT <= xpost[31:0];
        `OFS_XPOST_HI: RDATA_OUT <= {14'h0, xpost[49:32]};
        `OFS_LVL_LO: RDATA_OUT <= lvl[31:0];
        `OFS_LVL_HI: RDATA_OUT <= {20'h0, lvl[43:32]};
        `OFS_VBASE: RDATA_OUT <= {4'h0, vbase, 10'h000};
        `OFS_EDGE: RDATA_OUT <= {24'h0, tick_sel, port_pol};
        `OFS_STATE: RDATA_OUT <= {13'h0000, XFER_CH_OUT, XFER_REQ_OUT, CPU_LEVEL_OUT,
          1'b0, CPU_VECTOR_OUT, CPU_REQ_OUT};
        `OFS_IRQ_STAT: RDATA_OUT <= {30'h0, irq_stat};
        `OFS_IRQ_MASK: RDATA_OUT <= {30'h0, irq_mask};
        default: begin
          RDATA_OUT <= 32'h0;
          RRESP_OUT <= `RESP_DECERR;
        end
      endcase
    end else if (RVALID_OUT && RREADY_IN) begin
      RVALID_OUT <= 1'b0;
      ARREADY_OUT <= 1'b1;
    end
  end
endmodule

// ---- tb_top.sv ----
// Self-checking testbench of the maskable interrupt controller.
`timescale 1ns/1ps
`include "intc_consts.svh"
module tb_top;
  import intc_pkg::*;
  logic CORE_CLK_IN = 1'b0, RESET_IN = 1'b1, BOOT_AREA_SELECT_IN = 1'b1, CLK_COUNTUP_IN = 1'b0;
  logic [12:0] PORT_PIN_IN = 13'h0000;
  logic [48:8] PERIPH_EVENT_IN = '0;
  logic [3:0] CLK_TICK_IN = 4'h0, WSTRB_IN = 4'hf;
  logic NMI_PENDING_IN = 1'b0, XFER_DONE_IN = 1'b0, CPU_ACCEPT_ENABLE_IN;
  level_t CPU_PRIORITY_THRESHOLD_IN, CPU_LEVEL_OUT, thr = 4'h0;
  logic CPU_REQ_OUT, XFER_REQ_OUT, IRQ_OUT, AWREADY_OUT, WREADY_OUT, BVALID_OUT, ARREADY_OUT, RVALID_OUT;
  vector_t CPU_VECTOR_OUT, taken_vec, exp_v;
  logic [31:0] VECTOR_ADDR_OUT, RDATA_OUT, d;
  logic [4:0] XFER_CH_OUT;
  logic [1:0] BRESP_OUT, RRESP_OUT, r;
  logic [7:0] AWADDR_IN = 8'h00, ARADDR_IN = 8'h00;
  logic [31:0] WDATA_IN = 32'h0, base = 32'h0008_0000;
  logic AWVALID_IN = 1'b0, WVALID_IN = 1'b0, BREADY_IN = 1'b0, ARVALID_IN = 1'b0, RREADY_IN = 1'b0;
  logic load = 1'b0, en = 1'b0, stall = 1'b0, taken;
  vector_t expq[$];
  int failures = 0, comparisons = 0, seed = 6, s, n;

  maskable_interrupt_controller u_dut (.*);
  core_model u_core (.clk_in(CORE_CLK_IN), .rst_in(RESET_IN), .req_in(CPU_REQ_OUT), .vec_in(CPU_VECTOR_OUT),
    .lvl_in(CPU_LEVEL_OUT), .load_in(load), .en_in(en), .thr_in(thr), .stall_in(stall),
    .accept_enable_out(CPU_ACCEPT_ENABLE_IN), .threshold_out(CPU_PRIORITY_THRESHOLD_IN),
    .taken_out(taken), .taken_vec_out(taken_vec));

  // Clock of 200 MHz.
  always #2.5 CORE_CLK_IN = ~CORE_CLK_IN;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Write cycle: address and data offered together, each released when taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge CORE_CLK_IN);
    AWADDR_IN <= a;
    WDATA_IN <= dat;
    AWVALID_IN <= 1'b1;
    WVALID_IN <= 1'b1;
    BREADY_IN <= 1'b1;
    while (aw || w) begin
      @(posedge CORE_CLK_IN);
      if (aw && AWREADY_OUT) AWVALID_IN <= 1'b0;
      if (aw && AWREADY_OUT) aw = 1'b0;
      if (w && WREADY_OUT) WVALID_IN <= 1'b0;
      if (w && WREADY_OUT) w = 1'b0;
    end
    while (BVALID_OUT !== 1'b1) @(posedge CORE_CLK_IN);
    r = BRESP_OUT;
    BREADY_IN <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge CORE_CLK_IN);
    ARADDR_IN <= a;
    ARVALID_IN <= 1'b1;
    RREADY_IN <= 1'b1;
    do @(posedge CORE_CLK_IN); while (ARREADY_OUT !== 1'b1);
    ARVALID_IN <= 1'b0;
    do @(posedge CORE_CLK_IN); while (RVALID_OUT !== 1'b1);
    d = RDATA_OUT;
    r = RRESP_OUT;
    RREADY_IN <= 1'b0;
  endtask

  // Software update of the core's accept-enable and threshold.
  task automatic core(input logic e, input level_t t);
    @(posedge CORE_CLK_IN);
    en <= e;
    thr <= t;
    load <= 1'b1;
    @(posedge CORE_CLK_IN);
    load <= 1'b0;
  endtask

  task automatic fire(input int a, input int b);
    logic [48:8] p;
    p = '0;
    p[a] = 1'b1;
    p[b] = 1'b1;
    @(posedge CORE_CLK_IN);
    PERIPH_EVENT_IN <= p;
    @(posedge CORE_CLK_IN);
    PERIPH_EVENT_IN <= '0;
  endtask

  // Bounded wait until every expected trap has been accepted.
  task automatic drain();
    n = 0;
    while (expq.size() != 0 && n < 300) begin
      @(posedge CORE_CLK_IN);
      n++;
    end
    chk("traps left", 32'(expq.size()), 32'h0);
  endtask

  task automatic clr(input int f);
    if (f < 32) wr(`OFS_FLAG_LO, 32'h1 << f);
    else wr(`OFS_FLAG_HI, 32'h1 << (f - 32));
    core(1'b1, 4'h0);
  endtask

  // Two factors at once: the winner first, the loser stays pending.
  task automatic pair(input int w, input int l);
    expq.push_back(7'(16 + w));
    fire(w, l);
    drain();
    expq.push_back(7'(16 + l));
    clr(w);
    drain();
    clr(l);
  endtask

  // One factor with a slow core.
  task automatic one(input int f);
    expq.push_back(7'(16 + f));
    stall <= 1'b1;
    fire(f, f);
    repeat (4) @(posedge CORE_CLK_IN);
    stall <= 1'b0;
    drain();
    clr(f);
  endtask

  // Each accepted trap is compared with the oldest expectation.
  always @(posedge CORE_CLK_IN) begin
    if (taken === 1'b1) begin
      exp_v = (expq.size() != 0) ? expq.pop_front() : 7'h7f;
      chk("trap vector", 32'(taken_vec), 32'(exp_v));
      chk("vector address", VECTOR_ADDR_OUT, base + {23'h0, exp_v, 2'b00});
    end
  end

  // Hang guard, well beyond the length of the sequence.
  initial begin
    repeat (20000) @(posedge CORE_CLK_IN);
    failures++;
    end_of_test();
  end

  initial begin
    repeat (6) @(posedge CORE_CLK_IN);
    RESET_IN <= 1'b0;
    repeat (2) @(posedge CORE_CLK_IN);
    rd(`OFS_VBASE);
    chk("vector base", d, 32'h0008_0000);
    rd(8'h3c);
    chk("unmapped resp", 32'(r), 32'h3);
    // The state word is read-only; a write is refused and leaves it as it was.
    wr(`OFS_STATE, 32'hffff_ffff);
    chk("state write resp", 32'(r), 32'h3);
    rd(`OFS_STATE);
    chk("state idle", d, 32'h0000_0020);
    wr(`OFS_EN_LO, 32'hffff_ffff);
    chk("write resp", 32'(r), 32'h0);
    wr(`OFS_EN_HI, 32'h0003_ffff);
    wr(`OFS_LVL_LO, 32'h5555_5555);
    wr(`OFS_LVL_HI, 32'h0000_0555);
    core(1'b1, 4'h0);
    pair(12, 44);
    pair(12, 13);
    wr(`OFS_LVL_LO, 32'h5555_2555);
    wr(`OFS_LVL_HI, 32'h0000_0559);
    pair(44, 12);
    // Blocked by accept-enable, an equal threshold, then a pending NMI.
    core(1'b0, 4'h0);
    expq.push_back(7'h1a);
    fire(10, 10);
    core(1'b1, 4'h5);
    repeat (20) @(posedge CORE_CLK_IN);
    chk("equal level", 32'(expq.size()), 32'h1);
    NMI_PENDING_IN <= 1'b1;
    core(1'b1, 4'h0);
    repeat (20) @(posedge CORE_CLK_IN);
    chk("nmi blocks", 32'(expq.size()), 32'h1);
    NMI_PENDING_IN <= 1'b0;
    drain();
    clr(10);
    for (int i = 0; i < 4; i++) begin
      s = 8 + ($unsigned($random(seed)) % 41);
      if (s == 11 || s == 43 || s == 47) s = 12;
      one(s);
    end
    // Rising pin edge, a falling group edge, the second tick's falling edge and count-up.
    wr(`OFS_EDGE, 32'h0000_0041);
    expq.push_back(7'h10);
    PORT_PIN_IN[3] <= 1'b1;
    drain();
    clr(0);
    expq.push_back(7'h15);
    PORT_PIN_IN[8] <= 1'b1;
    repeat (8) @(posedge CORE_CLK_IN);
    chk("group rise ignored", 32'(expq.size()), 32'h1);
    PORT_PIN_IN[8] <= 1'b0;
    drain();
    clr(5);
    expq.push_back(7'h41);
    CLK_TICK_IN <= 4'h3;
    repeat (4) @(posedge CORE_CLK_IN);
    CLK_TICK_IN <= 4'h1;
    drain();
    clr(49);
    expq.push_back(7'h41);
    CLK_COUNTUP_IN <= 1'b1;
    @(posedge CORE_CLK_IN);
    CLK_COUNTUP_IN <= 1'b0;
    drain();
    clr(49);
    // Relocated table: later vector addresses follow the new base.
    wr(`OFS_VBASE, 32'h0012_3400);
    base = 32'h0012_3400;
    rd(`OFS_VBASE);
    chk("moved base", d, 32'h0012_3400);
    // Transfer first, then the request; a factor without a channel stays normal.
    wr(`OFS_XSEL_LO, 32'h0000_0500);
    wr(`OFS_XPOST_LO, 32'h0000_0100);
    wr(`OFS_IRQ_MASK, 32'h0000_0001);
    expq.push_back(7'h18);
    fire(8, 8);
    n = 0;
    while (XFER_REQ_OUT !== 1'b1 && n < 50) begin
      @(posedge CORE_CLK_IN);
      n++;
    end
    chk("channel", 32'(XFER_CH_OUT), 32'h5);
    repeat (5) @(posedge CORE_CLK_IN);
    chk("early trap", 32'(expq.size()), 32'h1);
    XFER_DONE_IN <= 1'b1;
    @(posedge CORE_CLK_IN);
    XFER_DONE_IN <= 1'b0;
    drain();
    chk("irq raised", 32'(IRQ_OUT), 32'h1);
    wr(`OFS_IRQ_STAT, 32'h0000_0001);
    repeat (3) @(posedge CORE_CLK_IN);
    chk("irq cleared", 32'(IRQ_OUT), 32'h0);
    clr(8);
    one(10);
    chk("no transfer", 32'(XFER_REQ_OUT), 32'h0);
    end_of_test();
  end
endmodule
